/* File: logic/tmf_defines.vh */
// constants for the tone map response framer
`ifndef TMF_DEFINES_VH
`define TMF_DEFINES_VH
`define TMF_CMD_BEACON_REQ 8'h07
`define TMF_CMD_TONE_RESP 8'h0a
`define TMF_LEN_CEN 4'd7
`define TMF_LEN_FCC 4'd12
`define TMF_SEG_TONE_REQ_BIT 3
`define TMF_MOD_QAM16 3'h4
`define TMF_MOD_ROBUST 3'h0
`define TMF_ADDR_CTRL 12'h000
`define TMF_ADDR_GAIN 12'h004
`define TMF_ADDR_MAPS 12'h008
`define TMF_ADDR_COEF_LO 12'h00c
`define TMF_ADDR_COEF_HI 12'h010
`define TMF_ADDR_STATUS 12'h014
`define TMF_ADDR_RXPAR 12'h018
`define TMF_ADDR_RXMAP 12'h01c
`define TMF_ADDR_RXCOEF_LO 12'h020
`define TMF_ADDR_RXCOEF_HI 12'h024
`define TMF_CTRL_RESET 32'h0000_0000
`endif

/* File: logic/tmf_fifo.v */
// no logic here: the response byte fifo module is kept in tmf_framer.v

/* File: logic/tmf_framer.v */
// tone map response framer: builds and parses the response command
`default_nettype none
`include "tmf_defines.vh"
module tmf_framer #(
  parameter FIFO_DEPTH = 8
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire seg_valid,
  input wire [7:0] seg_ctrl0,
  input wire rx_valid,
  input wire rx_first,
  input wire rx_last,
  input wire [7:0] rx_data,
  output wire tx_valid,
  input wire tx_ready,
  output wire [7:0] tx_data,
  output wire tx_robust,
  output reg rx_update
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [31:0] ctrl_q;
  reg [31:0] gain_q;
  reg [31:0] maps_q;
  reg [31:0] coef_lo_q;
  reg [31:0] coef_hi_q;
  reg [7:0] resp_cnt_q;
  reg [7:0] drop_cnt_q;
  reg pend_q;
  reg busy_q;
  reg [3:0] idx_q;
  reg [3:0] rx_idx_q;
  reg rx_ok_q;
  reg [95:0] rx_buf_q;
  reg [31:0] rxpar_q;
  reg [23:0] rxmap_q;
  reg [47:0] rxcoef_q;
  reg [7:0] byte_d;
  wire fcc = ctrl_q[0];
  wire band_b = ctrl_q[1];
  wire coherent = ctrl_q[2];
  wire en = ctrl_q[3];
  wire step_size = gain_q[8];
  wire [3:0] step_cnt = gain_q[7:4];
  wire [2:0] mod_req = gain_q[2:0];
  wire [7:0] link_quality_value = maps_q[31:24];
  wire [23:0] map = maps_q[23:0];
  wire [47:0] coef = {coef_hi_q[15:0], coef_lo_q};
  wire [3:0] last_idx = fcc ? `TMF_LEN_FCC : `TMF_LEN_CEN;
  wire fifo_in_ready;
  wire acc = psel & penable;
  // ----------------------------------------
  // field clamping
  // ----------------------------------------
  reg [2:0] mod_out;
  reg [5:0] cen_map;
  always @*
  begin
    mod_out = mod_req;
    if (fcc)
    begin
      if (mod_req > `TMF_MOD_QAM16 || (mod_req == `TMF_MOD_QAM16 && !coherent))
        mod_out = `TMF_MOD_ROBUST;
    end
    else
      mod_out = {1'b0, mod_req[1:0]};
    cen_map = band_b ? {3'b000, map[2:0]} : map[5:0];
  end
  // ----------------------------------------
  // byte builder
  // ----------------------------------------
  always @*
  begin
    byte_d = 8'h00;
    if (idx_q == 4'd0)
      byte_d = `TMF_CMD_TONE_RESP;
    else if (!fcc)
    begin
      case (idx_q)
        4'd1: byte_d = {step_size, step_cnt, mod_out[1:0], coherent};
        4'd2: byte_d = {2'b00, cen_map};
        4'd3: byte_d = link_quality_value;
        4'd4: byte_d = {coef[3:0], coef[7:4]};
        4'd5: byte_d = {coef[11:8], band_b ? 4'h0 : coef[15:12]};
        4'd6: byte_d = band_b ? 8'h00 : {coef[19:16], coef[23:20]};
        default: byte_d = 8'h00;
      endcase
    end
    else
    begin
      case (idx_q)
        4'd1: byte_d = {step_size, step_cnt, mod_out};
        4'd2: byte_d = map[7:0];
        4'd3: byte_d = map[15:8];
        4'd4: byte_d = map[23:16];
        4'd5: byte_d = link_quality_value;
        4'd6: byte_d = {coef[1:0], coef[3:2], coef[5:4], coef[7:6]};
        4'd7: byte_d = {coef[9:8], coef[11:10], coef[13:12], coef[15:14]};
        4'd8: byte_d = {coef[17:16], coef[19:18], coef[21:20], coef[23:22]};
        4'd9: byte_d = {coef[25:24], coef[27:26], coef[29:28], coef[31:30]};
        4'd10: byte_d = {coef[33:32], coef[35:34], coef[37:36], coef[39:38]};
        4'd11: byte_d = {coef[41:40], coef[43:42], coef[45:44], coef[47:46]};
        default: byte_d = {coherent, 7'h00};
      endcase
    end
  end
  // ----------------------------------------
  // transmit sequencer
  // ----------------------------------------
  wire trig = seg_valid & seg_ctrl0[`TMF_SEG_TONE_REQ_BIT] & en;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      idx_q <= 4'd0;
      resp_cnt_q <= 8'h00;
    end
    else if (ce)
    begin
      if (trig)
        pend_q <= 1'b1;
      else if (!busy_q & pend_q)
        pend_q <= 1'b0;
      if (!busy_q & pend_q)
      begin
        busy_q <= 1'b1;
        idx_q <= 4'd0;
      end
      else if (busy_q & fifo_in_ready)
      begin
        if (idx_q == last_idx)
        begin
          busy_q <= 1'b0;
          resp_cnt_q <= resp_cnt_q + 8'h01;
        end
        else
          idx_q <= idx_q + 4'd1;
      end
    end
  end
  assign tx_robust = 1'b1;
  tmf_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_valid(busy_q),
    .in_ready(fifo_in_ready),
    .in_data(byte_d),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
  // ----------------------------------------
  // receive parser
  // ----------------------------------------
  wire [47:0] rx_fcc_coef;
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1)
    begin : g_rx_coef
      assign rx_fcc_coef[2*gi+1:2*gi] = rx_buf_q[8*(5+gi/4)+7-2*(gi%4) -: 2];
    end
  endgenerate
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_idx_q <= 4'd0;
      rx_ok_q <= 1'b0;
      rx_buf_q <= 96'h0;
      rxpar_q <= 32'h0000_0000;
      rxmap_q <= 24'h00_0000;
      rxcoef_q <= 48'h0;
      drop_cnt_q <= 8'h00;
      rx_update <= 1'b0;
    end
    else if (ce)
    begin
      rx_update <= 1'b0;
      if (rx_valid)
      begin
        if (rx_first)
        begin
          rx_idx_q <= 4'd0;
          rx_ok_q <= (rx_data == `TMF_CMD_TONE_RESP);
          if (rx_data != `TMF_CMD_TONE_RESP && rx_data != `TMF_CMD_BEACON_REQ)
            drop_cnt_q <= drop_cnt_q + 8'h01;
        end
        else if (rx_ok_q && rx_idx_q < 4'd12)
        begin
          rx_buf_q[8*rx_idx_q +: 8] <= rx_data;
          rx_idx_q <= rx_idx_q + 4'd1;
        end
        if (rx_last & rx_ok_q & !rx_first)
        begin
          rx_ok_q <= 1'b0;
          if (rx_idx_q + 4'd1 == last_idx)
          begin
            rx_update <= 1'b1;
            if (!fcc)
            begin
              rxpar_q <= {16'h0, rx_buf_q[23:16], rx_buf_q[7:0]};
              rxmap_q <= {18'h0, rx_buf_q[13:8]};
              rxcoef_q <= {24'h0, rx_buf_q[43:40], rx_buf_q[47:44], rx_buf_q[35:32],
                rx_buf_q[39:36], rx_buf_q[27:24], rx_buf_q[31:28]};
            end
            else
            begin
              rxpar_q <= {15'h0, rx_data[7], rx_buf_q[39:32], rx_buf_q[7:0]};
              rxmap_q <= rx_buf_q[31:8];
              rxcoef_q <= rx_fcc_coef;
            end
          end
        end
      end
    end
  end
  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `TMF_CTRL_RESET;
      gain_q <= 32'h0000_0000;
      maps_q <= 32'h0000_0000;
      coef_lo_q <= 32'h0000_0000;
      coef_hi_q <= 32'h0000_0000;
    end
    else if (ce & acc & pwrite)
    begin
      case (paddr)
        `TMF_ADDR_CTRL: ctrl_q <= {28'h0, pwdata[3:0]};
        `TMF_ADDR_GAIN: gain_q <= {23'h0, pwdata[8:4], 1'b0, pwdata[2:0]};
        `TMF_ADDR_MAPS: maps_q <= pwdata;
        `TMF_ADDR_COEF_LO: coef_lo_q <= pwdata;
        `TMF_ADDR_COEF_HI: coef_hi_q <= {16'h0, pwdata[15:0]};
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end
  always @*
  begin
    case (paddr)
      `TMF_ADDR_CTRL: prdata = ctrl_q;
      `TMF_ADDR_GAIN: prdata = gain_q;
      `TMF_ADDR_MAPS: prdata = maps_q;
      `TMF_ADDR_COEF_LO: prdata = coef_lo_q;
      `TMF_ADDR_COEF_HI: prdata = coef_hi_q;
      `TMF_ADDR_STATUS: prdata = {14'h0, busy_q, pend_q, drop_cnt_q, resp_cnt_q};
      `TMF_ADDR_RXPAR: prdata = rxpar_q;
      `TMF_ADDR_RXMAP: prdata = {8'h0, rxmap_q};
      `TMF_ADDR_RXCOEF_LO: prdata = rxcoef_q[31:0];
      `TMF_ADDR_RXCOEF_HI: prdata = {16'h0, rxcoef_q[47:32]};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule // tmf_framer
// ----------------------------------------
// byte fifo
// ----------------------------------------
module tmf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;
  always @(posedge pclk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push & !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // tmf_fifo
`default_nettype wire

/* File: verif/tb.sv */
// testbench for the tone map response framer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, seg_valid = 1'b0, hold = 1'b0, fast = 1'b1, ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [7:0] seg_ctrl0 = 8'h00;
  logic pready, pslverr, rx_valid, rx_first, rx_last, tx_valid, tx_ready, tx_robust, rx_update;
  logic [7:0] rx_data, tx_data;
  int error_cnt = 0, n_checks = 0, cyc = 0, base = 0, n_upd = 0;
  always #5 pclk = ~pclk;
  tmf_framer DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .seg_valid, .seg_ctrl0, .rx_valid, .rx_first, .rx_last, .rx_data, .tx_valid, .tx_ready, .tx_data,
    .tx_robust, .rx_update);
  tmf_peer_model peer (.pclk, .hold, .fast, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_first, .rx_last,
    .rx_data);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
    chk("slave error", 32'h0000_0000, 32'(pslverr));
  endtask
  task automatic req(input logic [7:0] c);
    @(posedge pclk);
    seg_valid <= 1'b1;
    seg_ctrl0 <= c;
    @(posedge pclk);
    seg_valid <= 1'b0;
  endtask
  task automatic frame(input string nm, input logic [103:0] e, input int len);
    while (peer.n < base + len)
      @(posedge pclk);
    for (int i = 0; i < len; i++)
      chk(nm, 32'(e[103 - 8 * i -: 8]), 32'(peer.got[base + i]));
    base = base + len;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (rx_update)
      n_upd <= n_upd + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl reset", 12'h000, 32'h0000_0000);
    wr(12'h028, 32'hffff_ffff);
    rd("unmapped", 12'h028, 32'h0000_0000);
    wr(12'h000, 32'h0000_0008);
    wr(12'h004, 32'h0000_01d3);
    wr(12'h008, 32'h5a00_003f);
    wr(12'h00c, 32'h00ab_cdef);
    req(8'hf7);
    ce <= 1'b0;
    req(8'h08);
    ce <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("no request", 32'h0000_0000, 32'(peer.n));
    fast <= 1'b0;
    req(8'h08);
    req(8'h08);
    frame("cen", {64'h0aee_3f5a_fedc_ba00, 40'h00_0000_0000}, 8);
    frame("cen again", {64'h0aee_3f5a_fedc_ba00, 40'h00_0000_0000}, 8);
    fast <= 1'b1;
    wr(12'h000, 32'h0000_000e);
    req(8'h08);
    frame("cen b", {64'h0aef_075a_fed0_0000, 40'h00_0000_0000}, 8);
    wr(12'h000, 32'h0000_000d);
    wr(12'h004, 32'h0000_0054);
    wr(12'h008, 32'h773c_a581);
    wr(12'h00c, 32'h0000_00e4);
    hold <= 1'b1;
    req(8'h08);
    repeat (30) @(posedge pclk);
    hold <= 1'b0;
    frame("fcc", 104'h0a2c_81a5_3c77_1b00_0000_0000_80, 13);
    wr(12'h000, 32'h0000_0009);
    req(8'h08);
    frame("fcc qam diff", 104'h0a28_81a5_3c77_1b00_0000_0000_00, 13);
    wr(12'h000, 32'h0000_000d);
    wr(12'h004, 32'h0000_0057);
    req(8'h08);
    frame("fcc reserved mod", 104'h0a28_81a5_3c77_1b00_0000_0000_80, 13);
    peer.send(104'h0a2c_81a5_3c77_1b00_0000_0000_ff, 13);
    rd("rx param", 12'h018, 32'h0001_772c);
    rd("rx map", 12'h01c, 32'h003c_a581);
    rd("rx coef lo", 12'h020, 32'h0000_00e4);
    rd("rx coef hi", 12'h024, 32'h0000_0000);
    peer.send(104'h0b11_2233_4455_6600_0000_0000_00, 13);
    rd("rx param kept", 12'h018, 32'h0001_772c);
    peer.send(104'h0700_0000_0000_0000_0000_0000_00, 1);
    rd("status", 12'h014, 32'h0000_0106);
    wr(12'h000, 32'h0000_0008);
    peer.send({64'h0aee_3f5a_fedc_ba00, 40'h00_0000_0000}, 8);
    rd("rx param cen", 12'h018, 32'h0000_5aee);
    rd("rx map cen", 12'h01c, 32'h0000_003f);
    rd("rx coef cen", 12'h020, 32'h00ab_cdef);
    chk("updates", 32'h0000_0002, 32'(n_upd));
    chk("robust", 32'h0000_0001, 32'(tx_robust));
    final_report();
  end
endmodule // tb
bind tmf_framer tmf_framer_properties u_props (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .seg_valid, .seg_ctrl0, .rx_valid, .rx_first, .rx_last, .rx_data, .tx_valid, .tx_ready, .tx_data,
  .tx_robust, .rx_update);
`default_nettype wire

/* File: verif/tmf_framer_properties.sv */
// concurrent checks on the tone map response framer ports
`default_nettype none
module tmf_framer_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic seg_valid,
  input wire logic [7:0] seg_ctrl0,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_last,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_robust,
  input wire logic rx_update
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // byte position, enable and bandplan tracking
  // ----------------------------------------
  logic [3:0] idx_q;
  logic [1:0] ctl_q;
  logic seen_q;
  logic bad_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_q <= 4'h0;
      ctl_q <= 2'h0;
      seen_q <= 1'b0;
      bad_q <= 1'b0;
    end
    else
    begin
      if (ce && psel && penable && pwrite && pready && paddr == 12'h000)
        ctl_q <= {pwdata[3], pwdata[0]};
      if (ce && seg_valid && seg_ctrl0[3])
        seen_q <= 1'b1;
      if (rx_valid && rx_first)
        bad_q <= rx_data != 8'h0a;
      if (ce && tx_valid && tx_ready)
        idx_q <= (idx_q == (ctl_q[0] ? 4'hc : 4'h7)) ? 4'h0 : idx_q + 4'h1;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_robust_mode: assert property (tx_robust)
    else $error("response not sent robust");
  a_resp_ident: assert property (tx_valid && idx_q == 4'h0 |-> tx_data == 8'h0a)
    else $error("first byte is not the response identifier");
  a_cen_zero_bits: assert property (tx_valid && !ctl_q[0] |-> (idx_q != 4'h7 || tx_data == 8'h00)
    && (idx_q != 4'h2 || tx_data[7:6] == 2'h0))
    else $error("cenelec reserved bits not zero");
  a_fcc_tail: assert property (tx_valid && ctl_q[0] && idx_q == 4'hc |-> tx_data[6:0] == 7'h00)
    else $error("fcc last byte low bits not zero");
  a_fcc_mod_legal: assert property (tx_valid && ctl_q[0] && idx_q == 4'h1 |-> tx_data[2:0] <= 3'h4)
    else $error("fcc modulation code reserved");
  a_no_unrequested: assert property (!seen_q |-> !tx_valid)
    else $error("response without request");
  a_resp_delay: assert property (ce && seg_valid && seg_ctrl0[3] && ctl_q[1] && !seen_q |-> ##3 tx_valid)
    else $error("response not started in time");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped while stalled");
  a_upd_cause: assert property (rx_update |-> $past(rx_valid && rx_last) && !bad_q)
    else $error("update without valid response");
endmodule // tmf_framer_properties
`default_nettype wire

/* File: verif/tmf_peer_model.sv */
// peer mac model: sinks response bytes, sends command frames
`default_nettype none
module tmf_peer_model (
  input wire logic pclk,
  input wire logic hold,
  input wire logic fast,
  input wire logic tx_valid,
  output logic tx_ready = 1'b0,
  input wire logic [7:0] tx_data,
  output logic rx_valid = 1'b0,
  output logic rx_first = 1'b0,
  output logic rx_last = 1'b0,
  output logic [7:0] rx_data = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [0:63];
  int n = 0;
  logic ph = 1'b0;
  // ----------------------------------------
  // sink with stall and half rate pacing
  // ----------------------------------------
  always @(posedge pclk)
  begin
    ph <= ~ph;
    tx_ready <= ~hold & (fast | ph);
    if (tx_valid && tx_ready)
    begin
      got[n[5:0]] <= tx_data;
      n <= n + 1;
    end
  end
  // byte i sits left-justified in b; released data line shows the inverse
  task automatic send(input logic [103:0] b, input int len);
    for (int i = 0; i < len; i++)
    begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_first <= i == 0;
      rx_last <= i == len - 1;
      rx_data <= b[103 - 8 * i -: 8];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule // tmf_peer_model
`default_nettype wire
